// File: hdl/param_select_defines.svh
`ifndef PARAM_SELECT_DEFINES_SVH
`define PARAM_SELECT_DEFINES_SVH
// RAM destination codes
`define RAM_DEST_FREQ 2'h0
`define RAM_DEST_PHASE 2'h1
`define RAM_DEST_AMPL 2'h2
`define RAM_DEST_POLAR 2'h3
// Ramp generator destination codes
`define RAMP_DEST_FREQ 2'h0
`define RAMP_DEST_PHASE 2'h1
`define RAMP_DEST_AMPL 2'h2
// Parallel port destination field codes
`define PORT_DEST_AMPL 2'h0
`define PORT_DEST_PHASE 2'h1
`define PORT_DEST_FREQ 2'h2
`define PORT_DEST_POLAR 2'h3
// Field positions
`define RAM_PHASE_MSB 31
`define RAM_PHASE_LSB 16
`define RAM_AMPL_MSB 15
`define RAM_AMPL_LSB 2
`define RAMP_PHASE_LSB 16
`define RAMP_AMPL_LSB 18
`define PORT_DEST_MSB 1
`define PORT_DATA_LSB 2
// Reset values
`define FREQ_RST 32'h0
`define PHASE_RST 16'h0
`define AMPL_RST 14'h0
`endif

// File: hdl/param_select_pkg.sv
package param_select_pkg;
  // Which source currently drives each parameter
  typedef enum logic [2:0] {
    SRC_RAM, SRC_RAMP, SRC_PORT, SRC_PORT_LOW, SRC_SHIFT_KEY, SRC_SCALE_REG, SRC_PROFILE,
    SRC_NONE
  } source_e;
endpackage : param_select_pkg

// File: hdl/dds_param_select.sv
`timescale 1ns/1ps
`default_nettype none
`include "param_select_defines.svh"

module dds_param_select
  import param_select_pkg::*;
#(
  parameter int FREQ_W = 32,
  parameter int PHASE_W = 16,
  parameter int AMPL_W = 14,
  parameter int GAIN_W = 4
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ram_enable,
  input wire logic [1:0] ram_dest,
  input wire logic [31:0] ram_data,
  input wire logic ramp_generator_enable,
  input wire logic [1:0] ramp_generator_dest,
  input wire logic [31:0] ramp_generator_data,
  input wire logic port_enable,
  input wire logic [17:0] port_bus,
  input wire logic [GAIN_W-1:0] fm_gain,
  input wire logic shift_keying_enable,
  input wire logic shift_keying_auto,
  input wire logic [AMPL_W-1:0] shift_keying_data,
  input wire logic profile_ampl_enable,
  input wire logic [FREQ_W-1:0] tuning_word,
  input wire logic [PHASE_W-1:0] phase_offset_word,
  input wire logic [AMPL_W-1:0] amplitude_scale_factor,
  input wire logic [FREQ_W-1:0] profile_tuning_word,
  input wire logic [PHASE_W-1:0] profile_phase_offset_word,
  input wire logic [AMPL_W-1:0] profile_amplitude_scale_factor,
  output logic [FREQ_W-1:0] freq_out,
  output logic [PHASE_W-1:0] phase_out,
  output logic [AMPL_W-1:0] ampl_out,
  output source_e freq_src,
  output source_e phase_src,
  output source_e ampl_src
);

  logic [FREQ_W-1:0] freq_q, freq_d;
  logic [PHASE_W-1:0] phase_q, phase_d;
  logic [AMPL_W-1:0] ampl_q, ampl_d;
  source_e freq_src_q, freq_src_d, phase_src_q, phase_src_d, ampl_src_q, ampl_src_d;
  logic [1:0] port_dest;
  logic [15:0] port_word;

  // Port bus splits into destination field and data word
  assign port_dest = port_bus[`PORT_DEST_MSB:0];
  assign port_word = port_bus[17:`PORT_DATA_LSB];

  // Port word offsets the tuning word, shifted left by the gain setting
  function automatic logic [FREQ_W-1:0] fm_offset(input logic [15:0] w,
                                                   input logic [GAIN_W-1:0] g);
    logic [FREQ_W-1:0] wide;
    wide = FREQ_W'(w);
    fm_offset = wide << g;
  endfunction : fm_offset

  // Priority chains, re-evaluated from live enables every cycle
  always_comb begin
    // Frequency
    if (ram_enable && ram_dest == `RAM_DEST_FREQ) begin
      freq_d = ram_data;
      freq_src_d = SRC_RAM;
    end else if (ramp_generator_enable && ramp_generator_dest == `RAMP_DEST_FREQ) begin
      freq_d = ramp_generator_data;
      freq_src_d = SRC_RAMP;
    end else if (port_enable && port_dest == `PORT_DEST_FREQ) begin
      freq_d = tuning_word + fm_offset(port_word, fm_gain);
      freq_src_d = SRC_PORT;
    end else if (ram_enable) begin
      freq_d = tuning_word;
      freq_src_d = SRC_SCALE_REG;
    end else begin
      freq_d = profile_tuning_word;
      freq_src_d = SRC_PROFILE;
    end
    // Phase
    if (ram_enable && (ram_dest == `RAM_DEST_PHASE || ram_dest == `RAM_DEST_POLAR)) begin
      phase_d = ram_data[`RAM_PHASE_MSB:`RAM_PHASE_LSB];
      phase_src_d = SRC_RAM;
    end else if (ramp_generator_enable && ramp_generator_dest == `RAMP_DEST_PHASE) begin
      phase_d = ramp_generator_data[31:`RAMP_PHASE_LSB];
      phase_src_d = SRC_RAMP;
    end else if (port_enable && port_dest == `PORT_DEST_PHASE) begin
      phase_d = port_word;
      phase_src_d = SRC_PORT;
    end else if (port_enable && port_dest == `PORT_DEST_POLAR) begin
      phase_d = {port_word[7:0], phase_offset_word[7:0]};
      phase_src_d = SRC_PORT_LOW;
    end else if (ram_enable) begin
      phase_d = phase_offset_word;
      phase_src_d = SRC_SCALE_REG;
    end else begin
      phase_d = profile_phase_offset_word;
      phase_src_d = SRC_PROFILE;
    end
    // Amplitude
    if (shift_keying_enable && shift_keying_auto) begin
      ampl_d = shift_keying_data;
      ampl_src_d = SRC_SHIFT_KEY;
    end else if (shift_keying_enable) begin
      ampl_d = amplitude_scale_factor;
      ampl_src_d = SRC_SCALE_REG;
    end else if (ram_enable && (ram_dest == `RAM_DEST_AMPL || ram_dest == `RAM_DEST_POLAR)) begin
      ampl_d = ram_data[`RAM_AMPL_MSB:`RAM_AMPL_LSB];
      ampl_src_d = SRC_RAM;
    end else if (ramp_generator_enable && ramp_generator_dest == `RAMP_DEST_AMPL) begin
      ampl_d = ramp_generator_data[31:`RAMP_AMPL_LSB];
      ampl_src_d = SRC_RAMP;
    end else if (port_enable && port_dest == `PORT_DEST_AMPL) begin
      ampl_d = port_word[15:2];
      ampl_src_d = SRC_PORT;
    end else if (port_enable && port_dest == `PORT_DEST_POLAR) begin
      ampl_d = {port_word[15:8], amplitude_scale_factor[5:0]};
      ampl_src_d = SRC_PORT_LOW;
    end else if (profile_ampl_enable) begin
      ampl_d = profile_amplitude_scale_factor;
      ampl_src_d = SRC_PROFILE;
    end else begin
      ampl_d = {AMPL_W{1'b1}}; // No scaling: full scale
      ampl_src_d = SRC_NONE;
    end
  end

  // Register the selection so outputs come straight from flops
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      freq_q <= `FREQ_RST;
      phase_q <= `PHASE_RST;
      ampl_q <= `AMPL_RST;
      freq_src_q <= SRC_NONE;
      phase_src_q <= SRC_NONE;
      ampl_src_q <= SRC_NONE;
    end else begin
      freq_q <= freq_d;
      phase_q <= phase_d;
      ampl_q <= ampl_d;
      freq_src_q <= freq_src_d;
      phase_src_q <= phase_src_d;
      ampl_src_q <= ampl_src_d;
    end
  end

  assign freq_out = freq_q;
  assign phase_out = phase_q;
  assign ampl_out = ampl_q;
  assign freq_src = freq_src_q;
  assign phase_src = phase_src_q;
  assign ampl_src = ampl_src_q;

  // Checks
  a_ram_freq_wins: assert property (@(posedge ref_clk) disable iff (rst)
    ram_enable && ram_dest == `RAM_DEST_FREQ |=> freq_src == SRC_RAM && freq_out == $past(ram_data))
    else $error("RAM did not drive frequency");
  a_ramp_freq: assert property (@(posedge ref_clk) disable iff (rst)
    !(ram_enable && ram_dest == `RAM_DEST_FREQ) && ramp_generator_enable
    && ramp_generator_dest == `RAMP_DEST_FREQ |=> freq_src == SRC_RAMP)
    else $error("Ramp did not drive frequency");
  a_profile_freq: assert property (@(posedge ref_clk) disable iff (rst)
    !ram_enable && ramp_generator_enable && ramp_generator_dest != `RAMP_DEST_FREQ
    && !(port_enable && port_dest == `PORT_DEST_FREQ)
    |=> freq_out == $past(profile_tuning_word))
    else $error("Frequency not from profile");
  a_ram_phase: assert property (@(posedge ref_clk) disable iff (rst)
    ram_enable && ram_dest == `RAM_DEST_POLAR
    |=> phase_out == $past(ram_data[31:16]) && ampl_src != SRC_RAMP)
    else $error("Polar RAM phase wrong");
  a_ramp_phase: assert property (@(posedge ref_clk) disable iff (rst)
    !(ram_enable && ram_dest[0]) && ramp_generator_enable
    && ramp_generator_dest == `RAMP_DEST_PHASE |=> phase_out == $past(ramp_generator_data[31:16]))
    else $error("Ramp phase wrong");
  a_keying_first: assert property (@(posedge ref_clk) disable iff (rst)
    shift_keying_enable |=> ampl_src == SRC_SHIFT_KEY || ampl_src == SRC_SCALE_REG)
    else $error("Shift keying lost amplitude");
  a_ram_ampl: assert property (@(posedge ref_clk) disable iff (rst)
    !shift_keying_enable && ram_enable && ram_dest[1]
    |=> ampl_out == $past(ram_data[15:2]))
    else $error("RAM amplitude wrong");
  a_ramp_ampl: assert property (@(posedge ref_clk) disable iff (rst)
    !shift_keying_enable && !(ram_enable && ram_dest[1]) && ramp_generator_enable
    && ramp_generator_dest == `RAMP_DEST_AMPL |=> ampl_out == $past(ramp_generator_data[31:18]))
    else $error("Ramp amplitude wrong");
  a_enable_follows: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(shift_keying_enable) && shift_keying_auto |=> ampl_src == SRC_SHIFT_KEY)
    else $error("Enable change not followed");
  a_ramp_freq_data: assert property (@(posedge ref_clk) disable iff (rst)
    !(ram_enable && ram_dest == `RAM_DEST_FREQ) && ramp_generator_enable
    && ramp_generator_dest == `RAMP_DEST_FREQ |=> freq_out == $past(ramp_generator_data))
    else $error("Ramp frequency word wrong");
  // Port frequency is an offset on the tuning word; the sum wraps, so compare the difference
  a_port_freq_sum: assert property (@(posedge ref_clk) disable iff (rst)
    !(ram_enable && ram_dest == `RAM_DEST_FREQ)
    && !(ramp_generator_enable && ramp_generator_dest == `RAMP_DEST_FREQ)
    && port_enable && port_dest == `PORT_DEST_FREQ
    |=> freq_src == SRC_PORT
    && ((freq_out - $past(tuning_word)) == ($past(FREQ_W'(port_word)) << $past(fm_gain))))
    else $error("Port frequency offset wrong");
  a_port_polar_phase: assert property (@(posedge ref_clk) disable iff (rst)
    !(ram_enable && ram_dest[0])
    && !(ramp_generator_enable && ramp_generator_dest == `RAMP_DEST_PHASE)
    && port_enable && port_dest == `PORT_DEST_POLAR
    |=> phase_src == SRC_PORT_LOW
    && phase_out == {$past(port_word[7:0]), $past(phase_offset_word[7:0])})
    else $error("Port polar phase wrong");
  a_port_polar_ampl: assert property (@(posedge ref_clk) disable iff (rst)
    !shift_keying_enable && !(ram_enable && ram_dest[1])
    && !(ramp_generator_enable && ramp_generator_dest == `RAMP_DEST_AMPL)
    && port_enable && port_dest == `PORT_DEST_POLAR
    |=> ampl_src == SRC_PORT_LOW
    && ampl_out == {$past(port_word[15:8]), $past(amplitude_scale_factor[5:0])})
    else $error("Port polar amplitude wrong");
  a_auto_keying: assert property (@(posedge ref_clk) disable iff (rst)
    shift_keying_enable && shift_keying_auto |=> ampl_out == $past(shift_keying_data))
    else $error("Automatic shift keying amplitude wrong");
  a_manual_scale: assert property (@(posedge ref_clk) disable iff (rst)
    shift_keying_enable && !shift_keying_auto |=> ampl_out == $past(amplitude_scale_factor))
    else $error("Manual shift keying amplitude wrong");
  // One polar sample must feed both parameters in the same cycle
  a_polar_pair: assert property (@(posedge ref_clk) disable iff (rst)
    !shift_keying_enable && ram_enable && ram_dest == `RAM_DEST_POLAR
    |=> phase_src == SRC_RAM && ampl_src == SRC_RAM)
    else $error("Polar sample not shared");

endmodule : dds_param_select
`default_nettype wire

// File: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import param_select_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic ram_enable, ramp_generator_enable, port_enable, shift_keying_enable;
  logic shift_keying_auto, profile_ampl_enable;
  logic [1:0] ram_dest, ramp_generator_dest, pd;
  logic [3:0] fm_gain;
  logic [17:0] port_bus;
  logic [31:0] ram_data, ramp_generator_data, tuning_word, profile_tuning_word, freq_out, ef;
  logic [15:0] phase_offset_word, profile_phase_offset_word, phase_out, ep, w;
  logic [13:0] shift_keying_data, amplitude_scale_factor, profile_amplitude_scale_factor;
  logic [13:0] ampl_out, ea;
  source_e freq_src, phase_src, ampl_src, ef_s, ep_s, ea_s;
  int fail_count = 0;
  int comparisons = 0;
  int cycles = 0;

  dds_param_select u_dut (
    .ref_clk, .rst, .ram_enable, .ram_dest, .ram_data, .ramp_generator_enable,
    .ramp_generator_dest, .ramp_generator_data, .port_enable, .port_bus, .fm_gain,
    .shift_keying_enable, .shift_keying_auto, .shift_keying_data, .profile_ampl_enable,
    .tuning_word, .phase_offset_word, .amplitude_scale_factor, .profile_tuning_word,
    .profile_phase_offset_word, .profile_amplitude_scale_factor, .freq_out, .phase_out,
    .ampl_out, .freq_src, .phase_src, .ampl_src
  );

  // Core clock, 100 MHz
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Hang guard; the whole sweep needs a little over 4100 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      conclude();
    end
  end

  task automatic compare(input logic ok, input string what);
    comparisons++;
    if (ok !== 1'b1) begin
      fail_count++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask : compare

  // One code sets every enable and destination; data changes with it
  task automatic apply(input logic [11:0] c);
    {ram_enable, ram_dest, ramp_generator_enable, ramp_generator_dest, port_enable,
     port_bus[1:0], shift_keying_enable, shift_keying_auto, profile_ampl_enable} = c;
    port_bus[17:2] = {c, 4'h9} ^ 16'h5a3c;
    fm_gain = c[3:0] ^ c[7:4];
    ram_data = {c, 20'h13579} ^ 32'hc0de_0f0f;
    ramp_generator_data = ~ram_data + 32'(c);
  endtask : apply

  // Reference ranking, highest source first in each chain
  task automatic predict();
    pd = port_bus[1:0];
    w = port_bus[17:2];
    ef_s = (ram_enable && ram_dest == 2'h0) ? SRC_RAM :
      (ramp_generator_enable && ramp_generator_dest == 2'h0) ? SRC_RAMP :
      (port_enable && pd == 2'h2) ? SRC_PORT : ram_enable ? SRC_SCALE_REG : SRC_PROFILE;
    ep_s = (ram_enable && ram_dest[0]) ? SRC_RAM :
      (ramp_generator_enable && ramp_generator_dest == 2'h1) ? SRC_RAMP :
      (port_enable && pd == 2'h1) ? SRC_PORT : (port_enable && pd == 2'h3) ? SRC_PORT_LOW :
      ram_enable ? SRC_SCALE_REG : SRC_PROFILE;
    ea_s = (shift_keying_enable && shift_keying_auto) ? SRC_SHIFT_KEY :
      shift_keying_enable ? SRC_SCALE_REG : (ram_enable && ram_dest[1]) ? SRC_RAM :
      (ramp_generator_enable && ramp_generator_dest == 2'h2) ? SRC_RAMP :
      (port_enable && pd == 2'h0) ? SRC_PORT : (port_enable && pd == 2'h3) ? SRC_PORT_LOW :
      profile_ampl_enable ? SRC_PROFILE : SRC_NONE;
    ef = (ef_s == SRC_RAM) ? ram_data : (ef_s == SRC_RAMP) ? ramp_generator_data :
      (ef_s == SRC_PORT) ? tuning_word + (32'(w) << fm_gain) :
      (ef_s == SRC_SCALE_REG) ? tuning_word : profile_tuning_word;
    ep = (ep_s == SRC_RAM) ? ram_data[31:16] : (ep_s == SRC_RAMP) ? ramp_generator_data[31:16] :
      (ep_s == SRC_PORT) ? w : (ep_s == SRC_PORT_LOW) ? {w[7:0], phase_offset_word[7:0]} :
      (ep_s == SRC_SCALE_REG) ? phase_offset_word : profile_phase_offset_word;
    ea = (ea_s == SRC_SHIFT_KEY) ? shift_keying_data :
      (ea_s == SRC_SCALE_REG) ? amplitude_scale_factor :
      (ea_s == SRC_RAM) ? ram_data[15:2] : (ea_s == SRC_RAMP) ? ramp_generator_data[31:18] :
      (ea_s == SRC_PORT) ? w[15:2] :
      (ea_s == SRC_PORT_LOW) ? {w[15:8], amplitude_scale_factor[5:0]} :
      (ea_s == SRC_PROFILE) ? profile_amplitude_scale_factor : 14'h3fff;
  endtask : predict

  task automatic conclude();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : conclude

  // Exhaustive sweep of every enable and destination, a new code each cycle
  initial begin
    apply(12'h000);
    tuning_word = 32'h1357_9bdf;
    profile_tuning_word = 32'h2468_ace0;
    phase_offset_word = 16'h3c5a;
    profile_phase_offset_word = 16'h9e71;
    amplitude_scale_factor = 14'h2b6d;
    profile_amplitude_scale_factor = 14'h1492;
    shift_keying_data = 14'h0e3b;
    repeat (4) @(negedge ref_clk);
    rst = 1'b0;
    for (int i = 0; i < 4096; i++) begin
      apply(12'(i));
      predict();
      @(negedge ref_clk);
      compare(freq_out === ef && freq_src === ef_s, "frequency");
      compare(phase_out === ep && phase_src === ep_s, "phase");
      compare(ampl_out === ea && ampl_src === ea_s, "amplitude");
    end
    // Reset in mid-run clears the outputs at once
    rst = 1'b1;
    #1;
    compare(freq_out === 32'h0 && ampl_src === SRC_NONE, "reset");
    // Release in mid-run: the first edge after release must already pick RAM for frequency
    @(negedge ref_clk);
    apply(12'h800);
    predict();
    rst = 1'b0;
    compare(freq_src === SRC_NONE && phase_out === 16'h0, "held in reset");
    @(negedge ref_clk);
    compare(freq_out === ef && freq_src === ef_s && phase_out === ep && ampl_out === ea,
            "first cycle after reset");
    conclude();
  end
endmodule : tb_top
`default_nettype wire
